// [verilog/stf_pkg.sv]
// Package for the speed threshold flag block: setting indices, defaults, ranges,
// control modes and output terminal function codes.
// Assumes speeds arrive as signed whole r/min values on the control clock.
`default_nettype none

package stf_pkg;

  localparam int SPEED_W = 16;
  localparam int SET_W   = 14;
  localparam int IDX_W   = 4;
  localparam int N_SET   = 9;

  // Setting indices in the parameter store.
  localparam logic [IDX_W-1:0] IDX_SENS     = 4'h0;
  localparam logic [IDX_W-1:0] IDX_THR1     = 4'h1;
  localparam logic [IDX_W-1:0] IDX_REV_THR  = 4'h2;
  localparam logic [IDX_W-1:0] IDX_THR2     = 4'h3;
  localparam logic [IDX_W-1:0] IDX_THR3     = 4'h4;
  localparam logic [IDX_W-1:0] IDX_SEL_A    = 4'h5;
  localparam logic [IDX_W-1:0] IDX_SEL_B    = 4'h6;
  localparam logic [IDX_W-1:0] IDX_SEL_C    = 4'h7;
  localparam logic [IDX_W-1:0] IDX_SEL_RLY  = 4'h8;

  // Ranges and the special value that ties the reverse threshold to the forward one.
  localparam logic [SET_W-1:0] SENS_MAX     = 14'h0064;
  localparam logic [SET_W-1:0] SPEED_MAX    = 14'h0e10;
  localparam logic [SET_W-1:0] SAME_AS_FWD  = 14'h270f;
  localparam int               PERCENT      = 100;

  // Output terminal function codes.
  localparam logic [SET_W-1:0] FUNC_AT_SPEED = 14'h0001;
  localparam logic [SET_W-1:0] FUNC_CMD1     = 14'h0004;
  localparam logic [SET_W-1:0] FUNC_CMD2     = 14'h0005;
  localparam logic [SET_W-1:0] FUNC_CMD3     = 14'h0006;
  localparam logic [SET_W-1:0] FUNC_FBK1     = 14'h0007;
  localparam logic [SET_W-1:0] FUNC_FBK2     = 14'h0008;
  localparam logic [SET_W-1:0] FUNC_FBK3     = 14'h0009;
  localparam logic [SET_W-1:0] FUNC_NONE     = 14'h270f;

  // Reset values of the settings.
  localparam logic [SET_W-1:0] SENS_RST      = 14'h000a;
  localparam logic [SET_W-1:0] THR1_RST      = 14'h012c;
  localparam logic [SET_W-1:0] REV_THR_RST   = 14'h270f;
  localparam logic [SET_W-1:0] THR2_RST      = 14'h02ee;
  localparam logic [SET_W-1:0] THR3_RST      = 14'h05dc;
  localparam logic [SET_W-1:0] SEL_A_RST     = 14'h270f;
  localparam logic [SET_W-1:0] SEL_B_RST     = 14'h0001;
  localparam logic [SET_W-1:0] SEL_C_RST     = 14'h270f;
  localparam logic [SET_W-1:0] SEL_RLY_RST   = 14'h270f;

  localparam logic [SET_W-1:0] SET_RST [N_SET] = '{
    SENS_RST, THR1_RST, REV_THR_RST, THR2_RST, THR3_RST,
    SEL_A_RST, SEL_B_RST, SEL_C_RST, SEL_RLY_RST
  };

  typedef enum logic [1:0] {
    MODE_SPEED    = 2'h0,
    MODE_VF       = 2'h1,
    MODE_TORQUE   = 2'h3,
    MODE_POSITION = 2'h2
  } stf_mode_t;

endpackage : stf_pkg

`default_nettype wire

// [verilog/stf_param_store.sv]
// Small register store for the block's settings, with one write port,
// one registered read port and every entry visible in parallel.
// Assumes writes are already checked for range by the caller.
`timescale 1ns/100ps
`default_nettype none

module stf_param_store #(
  parameter int                 DEPTH = 9,
  parameter int                 WIDTH = 14,
  parameter int                 AW    = 4,
  parameter logic [WIDTH-1:0]   INIT [DEPTH] = '{default: '0}
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [WIDTH-1:0] rd_data,
  output var  logic [WIDTH-1:0] entry [DEPTH]
);

  always_ff @(posedge clk) begin
    if (reset) begin
      entry <= INIT;
    end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
      entry[wr_addr] <= wr_data;
    end
  end

  // Unmapped read addresses return zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= '0;
    end else if (int'(rd_addr) < DEPTH) begin
      rd_data <= entry[rd_addr];
    end else begin
      rd_data <= '0;
    end
  end

endmodule : stf_param_store

`default_nettype wire

// [verilog/stf_speed_flags.sv]
// Speed threshold flags: up-to-speed and six speed detection flags routed to
// three digital outputs and one relay contact output.
// Assumes speeds and alarm come from logic on clk; start and the two inputs
// from terminals are asynchronous and are synchronised here.
//
// Operation
// - Up-to-speed sensitivity setting, 0 to 100 percent, resets to 10.
// - With encoder vector control, up-to-speed uses measured speed feedback.
// - Output b carries up-to-speed after reset; function code 1 selects it.
// - Detection flags appear only on terminals whose selection names them.
// - First flag on at or above first threshold, 0 to 3600, default 300.
// - Forward rotation uses first threshold, reverse uses the reverse threshold.
// - Reverse threshold 9999 means same as first threshold; default 9999.
// - Second flags on at or above second threshold, default 750, both directions.
// - Third flags on at or above third threshold, default 1500, both directions.
// - Command flags compare against the speed command.
// - Feedback flags use measured speed, or estimated speed without encoder.
// - Command flags work in speed and V/F control only.
// - In V/F control both flag sets use speed from output frequency.
// - Speed command used is the ramped command, not the raw setpoint.
// - Detection flags clear on alarm, output stop or reset input.
// - A zero threshold turns its flag on as soon as start is active.
`timescale 1ns/100ps
`default_nettype none

module stf_speed_flags #(
  parameter int SPEED_W = stf_pkg::SPEED_W,
  parameter int SET_W   = stf_pkg::SET_W
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic [1:0]                ctrl_mode,
  input  wire logic                      encoder_present,
  input  wire logic signed [SPEED_W-1:0] speed_command,
  input  wire logic signed [SPEED_W-1:0] speed_feedback,
  input  wire logic signed [SPEED_W-1:0] speed_estimate,
  input  wire logic signed [SPEED_W-1:0] speed_from_freq,
  input  wire logic signed [SPEED_W-1:0] speed_setpoint,
  input  wire logic                      alarm,
  input  wire logic                      start_cmd,
  input  wire logic                      output_stop_input,
  input  wire logic                      drive_reset_input,
  input  wire logic                      param_write,
  input  wire logic [3:0]                param_index,
  input  wire logic [SET_W-1:0]          param_data,
  input  wire logic [3:0]                param_read_index,
  output var  logic [SET_W-1:0]          param_read_data,
  output var  logic                      param_write_error,
  output var  logic                      at_speed_flag,
  output var  logic                      cmd_speed_detect1,
  output var  logic                      cmd_speed_detect2,
  output var  logic                      cmd_speed_detect3,
  output var  logic                      fbk_speed_detect1,
  output var  logic                      fbk_speed_detect2,
  output var  logic                      fbk_speed_detect3,
  output var  logic                      digital_out_a,
  output var  logic                      digital_out_b,
  output var  logic                      digital_out_c,
  output var  logic                      relay_contact_out
);

  logic [SET_W-1:0]          setting [stf_pkg::N_SET];
  logic                      write_ok;
  logic [2:0]                pin_meta;
  logic [2:0]                pin_sync;
  logic                      start_on;
  logic                      stop_on;
  logic                      rst_in_on;
  logic                      clear_flags;
  logic                      cmd_enabled;
  logic signed [SPEED_W-1:0] cmd_speed;
  logic signed [SPEED_W-1:0] fbk_speed;
  logic signed [SPEED_W-1:0] band_speed;
  logic [SET_W-1:0]          at_speed_sens;
  logic [SET_W-1:0]          thr1;
  logic [SET_W-1:0]          rev_thr;
  logic [SET_W-1:0]          thr2;
  logic [SET_W-1:0]          thr3;
  logic                      next_at_speed;
  logic [6:0]                flag_vec;

  function automatic logic [SPEED_W:0] speed_mag(input logic signed [SPEED_W:0] s);
    speed_mag = s[SPEED_W] ? (SPEED_W+1)'(-s) : (SPEED_W+1)'(s);
  endfunction : speed_mag

  // First-threshold choice by rotation sense, with 9999 meaning "as forward".
  function automatic logic [SET_W-1:0] thr1_for(input logic signed [SPEED_W-1:0] s,
                                                input logic [SET_W-1:0] fwd,
                                                input logic [SET_W-1:0] rev);
    if (s[SPEED_W-1] && (rev != stf_pkg::SAME_AS_FWD)) begin
      thr1_for = rev;
    end else begin
      thr1_for = fwd;
    end
  endfunction : thr1_for

  // A zero threshold follows start, since a speed compare at zero would
  // otherwise hold the flag on even while the drive is stopped.
  function automatic logic reached(input logic signed [SPEED_W-1:0] s,
                                   input logic [SET_W-1:0] thr,
                                   input logic start);
    if (thr == '0) begin
      reached = start;
    end else begin
      reached = speed_mag({s[SPEED_W-1], s}) >= (SPEED_W+1)'(thr);
    end
  endfunction : reached

  function automatic logic route(input logic [SET_W-1:0] sel, input logic [6:0] f);
    unique case (sel)
      stf_pkg::FUNC_AT_SPEED: route = f[0];
      stf_pkg::FUNC_CMD1:     route = f[1];
      stf_pkg::FUNC_CMD2:     route = f[2];
      stf_pkg::FUNC_CMD3:     route = f[3];
      stf_pkg::FUNC_FBK1:     route = f[4];
      stf_pkg::FUNC_FBK2:     route = f[5];
      stf_pkg::FUNC_FBK3:     route = f[6];
      default:                route = 1'b0;
    endcase
  endfunction : route

  function automatic logic setting_legal(input logic [3:0] idx, input logic [SET_W-1:0] d);
    unique case (idx)
      stf_pkg::IDX_SENS:    setting_legal = d <= stf_pkg::SENS_MAX;
      stf_pkg::IDX_THR1,
      stf_pkg::IDX_THR2,
      stf_pkg::IDX_THR3:    setting_legal = d <= stf_pkg::SPEED_MAX;
      stf_pkg::IDX_REV_THR: setting_legal = (d <= stf_pkg::SPEED_MAX) ||
                                            (d == stf_pkg::SAME_AS_FWD);
      stf_pkg::IDX_SEL_A,
      stf_pkg::IDX_SEL_B,
      stf_pkg::IDX_SEL_C,
      stf_pkg::IDX_SEL_RLY: setting_legal = (d == stf_pkg::FUNC_NONE) ||
                                            (d == stf_pkg::FUNC_AT_SPEED) ||
                                            ((d >= stf_pkg::FUNC_CMD1) &&
                                             (d <= stf_pkg::FUNC_FBK3));
      default:              setting_legal = 1'b0;
    endcase
  endfunction : setting_legal

  // Out-of-range writes are dropped whole so a stored setting is always legal.
  assign write_ok = param_write && setting_legal(param_index, param_data);

  stf_param_store #(
    .DEPTH (stf_pkg::N_SET),
    .WIDTH (SET_W),
    .AW    (stf_pkg::IDX_W),
    .INIT  (stf_pkg::SET_RST)
  ) u_store (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (write_ok),
    .wr_addr (param_index),
    .wr_data (param_data),
    .rd_addr (param_read_index),
    .rd_data (param_read_data),
    .entry   (setting)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      param_write_error <= 1'b0;
    end else begin
      param_write_error <= param_write && !write_ok;
    end
  end

  assign at_speed_sens = setting[stf_pkg::IDX_SENS];
  assign thr1          = setting[stf_pkg::IDX_THR1];
  assign rev_thr       = setting[stf_pkg::IDX_REV_THR];
  assign thr2          = setting[stf_pkg::IDX_THR2];
  assign thr3          = setting[stf_pkg::IDX_THR3];

  // Terminal inputs cross two flip-flops before use.
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {start_cmd, output_stop_input, drive_reset_input};
      pin_sync <= pin_meta;
    end
  end

  assign start_on    = pin_sync[2];
  assign stop_on     = pin_sync[1];
  assign rst_in_on   = pin_sync[0];
  assign clear_flags = alarm || stop_on || rst_in_on;
  assign cmd_enabled = (ctrl_mode == stf_pkg::MODE_SPEED) ||
                       (ctrl_mode == stf_pkg::MODE_VF);

  // Speed sources; the command input is the post-ramp command.
  always_comb begin
    if (ctrl_mode == stf_pkg::MODE_VF) begin
      cmd_speed  = speed_from_freq;
      fbk_speed  = speed_from_freq;
      band_speed = speed_from_freq;
    end else begin
      cmd_speed  = speed_command;
      fbk_speed  = encoder_present ? speed_feedback : speed_estimate;
      band_speed = encoder_present ? speed_feedback : speed_command;
    end
  end

  // Error and band are compared by cross-multiplying, avoiding a divider.
  always_comb begin
    logic signed [SPEED_W:0] diff;
    logic [31:0]             lhs;
    logic [31:0]             rhs;
    diff = {band_speed[SPEED_W-1], band_speed} - {speed_setpoint[SPEED_W-1], speed_setpoint};
    lhs  = 32'(speed_mag(diff)) * 32'(stf_pkg::PERCENT);
    rhs  = 32'(at_speed_sens) * 32'(speed_mag({speed_setpoint[SPEED_W-1], speed_setpoint}));
    next_at_speed = lhs <= rhs;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      at_speed_flag <= 1'b0;
    end else begin
      at_speed_flag <= next_at_speed;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || clear_flags || !cmd_enabled) begin
      cmd_speed_detect1 <= 1'b0;
      cmd_speed_detect2 <= 1'b0;
      cmd_speed_detect3 <= 1'b0;
    end else begin
      cmd_speed_detect1 <= reached(cmd_speed, thr1_for(cmd_speed, thr1, rev_thr), start_on);
      cmd_speed_detect2 <= reached(cmd_speed, thr2, start_on);
      cmd_speed_detect3 <= reached(cmd_speed, thr3, start_on);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || clear_flags) begin
      fbk_speed_detect1 <= 1'b0;
      fbk_speed_detect2 <= 1'b0;
      fbk_speed_detect3 <= 1'b0;
    end else begin
      fbk_speed_detect1 <= reached(fbk_speed, thr1_for(fbk_speed, thr1, rev_thr), start_on);
      fbk_speed_detect2 <= reached(fbk_speed, thr2, start_on);
      fbk_speed_detect3 <= reached(fbk_speed, thr3, start_on);
    end
  end

  assign flag_vec = {fbk_speed_detect3, fbk_speed_detect2, fbk_speed_detect1,
                     cmd_speed_detect3, cmd_speed_detect2, cmd_speed_detect1, at_speed_flag};

  always_ff @(posedge clk) begin
    if (reset) begin
      digital_out_a     <= 1'b0;
      digital_out_b     <= 1'b0;
      digital_out_c     <= 1'b0;
      relay_contact_out <= 1'b0;
    end else begin
      digital_out_a     <= route(setting[stf_pkg::IDX_SEL_A], flag_vec);
      digital_out_b     <= route(setting[stf_pkg::IDX_SEL_B], flag_vec);
      digital_out_c     <= route(setting[stf_pkg::IDX_SEL_C], flag_vec);
      relay_contact_out <= route(setting[stf_pkg::IDX_SEL_RLY], flag_vec);
    end
  end

  default clocking dflt_cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence stop_held_s;
    output_stop_input [*3];
  endsequence

  sequence reset_in_held_s;
    drive_reset_input [*3];
  endsequence

  alarm_clears_a: assert property (alarm |=> !cmd_speed_detect1 &&
      !cmd_speed_detect2 && !cmd_speed_detect3 &&
      !fbk_speed_detect1 && !fbk_speed_detect2 && !fbk_speed_detect3)
    else $error("Detection flag on after alarm.");

  stop_clears_a: assert property (stop_held_s or reset_in_held_s |=>
      !fbk_speed_detect1 && !fbk_speed_detect2 && !fbk_speed_detect3 && !cmd_speed_detect1)
    else $error("Detection flag on after stop or reset input.");

  cmd_mode_gate_a: assert property (!cmd_enabled |=>
      !cmd_speed_detect1 && !cmd_speed_detect2 && !cmd_speed_detect3)
    else $error("Command flag on outside speed and V/F control.");

  thr2_reached_a: assert property (!clear_flags && cmd_enabled && thr2 != '0 &&
      speed_mag({cmd_speed[SPEED_W-1], cmd_speed}) >= (SPEED_W+1)'(thr2)
      |=> cmd_speed_detect2)
    else $error("Second command flag missed.");

  thr3_fbk_a: assert property (!clear_flags && thr3 != '0 &&
      speed_mag({fbk_speed[SPEED_W-1], fbk_speed}) < (SPEED_W+1)'(thr3)
      |=> !fbk_speed_detect3)
    else $error("Third feedback flag on below threshold.");

  reverse_thr_a: assert property (!clear_flags && fbk_speed[SPEED_W-1] &&
      rev_thr != stf_pkg::SAME_AS_FWD && rev_thr != '0 &&
      speed_mag({fbk_speed[SPEED_W-1], fbk_speed}) >= (SPEED_W+1)'(rev_thr)
      |=> fbk_speed_detect1)
    else $error("Reverse threshold not applied.");

  vf_same_a: assert property (ctrl_mode == stf_pkg::MODE_VF |=>
      cmd_speed_detect1 == fbk_speed_detect1 && cmd_speed_detect3 == fbk_speed_detect3)
    else $error("Command and feedback flags differ in V/F control.");

  zero_thr_start_a: assert property (!clear_flags && thr2 == '0 && start_on |=>
      fbk_speed_detect2)
    else $error("Zero threshold flag not on with start.");

  term_route_a: assert property (setting[stf_pkg::IDX_SEL_B] == stf_pkg::FUNC_AT_SPEED
      ##1 setting[stf_pkg::IDX_SEL_B] == stf_pkg::FUNC_AT_SPEED
      |=> digital_out_b == $past(at_speed_flag))
    else $error("Output b does not follow up-to-speed.");

  band_zero_a: assert property (at_speed_sens == '0 && band_speed != speed_setpoint
      |=> !at_speed_flag)
    else $error("Up-to-speed on outside a zero band.");

endmodule : stf_speed_flags

`default_nettype wire

// [dv/stf_term_reader.sv]
// Partner model: outside equipment that reads the four output terminals.
// Assumes the terminal levels are settled on the control clock.
`timescale 1ns/100ps
`default_nettype none

module stf_term_reader (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       term_a,
  input  wire logic       term_b,
  input  wire logic       term_c,
  input  wire logic       term_rly,
  output var  logic [3:0] term_seen
);
  // Sampling on the clock registers the four levels once; a one-cycle pulse still reads through.
  always_ff @(posedge clk) begin
    if (reset) begin
      term_seen <= 4'h0;
    end else begin
      term_seen <= {term_a, term_b, term_c, term_rly};
    end
  end
endmodule : stf_term_reader

`default_nettype wire

// [dv/tb_speed_threshold_flags.sv]
// Self-checking bench for the speed threshold flag block.
// Assumes the design files and stf_term_reader are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_speed_threshold_flags;
  logic               clk, reset, encoder_present, alarm, start_cmd;
  logic               output_stop_input, drive_reset_input, param_write;
  logic [1:0]         ctrl_mode;
  logic signed [15:0] speed_command, speed_feedback, speed_estimate;
  logic signed [15:0] speed_from_freq, speed_setpoint;
  logic [3:0]         param_index, param_read_index, term_seen;
  logic [13:0]        param_data, param_read_data;
  logic               param_write_error, at_speed_flag;
  logic               cmd_speed_detect1, cmd_speed_detect2, cmd_speed_detect3;
  logic               fbk_speed_detect1, fbk_speed_detect2, fbk_speed_detect3;
  logic               digital_out_a, digital_out_b, digital_out_c, relay_contact_out;
  int                 n_mismatch, samples_checked;
  logic [13:0]        dflt [9] = '{14'h000a, 14'h012c, 14'h270f, 14'h02ee, 14'h05dc,
                                   14'h270f, 14'h0001, 14'h270f, 14'h270f};
  logic [13:0]        codes [8] = '{14'h0001, 14'h0004, 14'h0005, 14'h0006, 14'h0007,
                                    14'h0008, 14'h0009, 14'h270f};
  logic               e1, e2;

  stf_speed_flags u_dut (
    .clk(clk), .reset(reset), .ctrl_mode(ctrl_mode), .encoder_present(encoder_present),
    .speed_command(speed_command), .speed_feedback(speed_feedback),
    .speed_estimate(speed_estimate), .speed_from_freq(speed_from_freq),
    .speed_setpoint(speed_setpoint), .alarm(alarm), .start_cmd(start_cmd),
    .output_stop_input(output_stop_input), .drive_reset_input(drive_reset_input),
    .param_write(param_write), .param_index(param_index), .param_data(param_data),
    .param_read_index(param_read_index), .param_read_data(param_read_data),
    .param_write_error(param_write_error), .at_speed_flag(at_speed_flag),
    .cmd_speed_detect1(cmd_speed_detect1), .cmd_speed_detect2(cmd_speed_detect2),
    .cmd_speed_detect3(cmd_speed_detect3), .fbk_speed_detect1(fbk_speed_detect1),
    .fbk_speed_detect2(fbk_speed_detect2), .fbk_speed_detect3(fbk_speed_detect3),
    .digital_out_a(digital_out_a), .digital_out_b(digital_out_b),
    .digital_out_c(digital_out_c), .relay_contact_out(relay_contact_out)
  );

  stf_term_reader u_reader (
    .clk(clk), .reset(reset), .term_a(digital_out_a), .term_b(digital_out_b),
    .term_c(digital_out_c), .term_rly(relay_contact_out), .term_seen(term_seen)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Five edges cover the two-stage terminal sync, the flag and the routed output.
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask : settle

  task automatic cf(input string what, input logic [6:0] exp);
    chk(what, {9'h000, at_speed_flag, cmd_speed_detect1, cmd_speed_detect2,
        cmd_speed_detect3, fbk_speed_detect1, fbk_speed_detect2, fbk_speed_detect3},
        {9'h000, exp});
  endtask : cf

  task automatic drive(input logic [1:0] mode, input logic enc,
                       input logic signed [15:0] cmd, input logic signed [15:0] fb,
                       input logic signed [15:0] est, input logic signed [15:0] vf,
                       input logic signed [15:0] sp);
    @(posedge clk);
    ctrl_mode       <= mode;
    encoder_present <= enc;
    speed_command   <= cmd;
    speed_feedback  <= fb;
    speed_estimate  <= est;
    speed_from_freq <= vf;
    speed_setpoint  <= sp;
    settle();
  endtask : drive

  // The refusal pulse is looked for over both cycles after the taking edge.
  task automatic wr(input logic [3:0] idx, input logic [13:0] data, input logic exp_err);
    logic err;
    @(posedge clk);
    param_write <= 1'b1;
    param_index <= idx;
    param_data  <= data;
    @(posedge clk);
    param_write <= 1'b0;
    #1;
    err = param_write_error;
    @(posedge clk);
    #1;
    err = err | param_write_error;
    chk("write error", {15'h0000, err}, {15'h0000, exp_err});
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [13:0] exp);
    @(posedge clk);
    param_read_index <= idx;
    repeat (2) @(posedge clk);
    #1;
    chk("readback", {2'h0, param_read_data}, {2'h0, exp});
  endtask : rd

  initial begin
    #5000000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    reset = 1'b1;
    {encoder_present, alarm, start_cmd, output_stop_input, drive_reset_input} = 5'h00;
    {param_write, ctrl_mode, param_index, param_read_index, param_data} = '0;
    {speed_command, speed_feedback, speed_estimate, speed_from_freq} = '0;
    speed_setpoint = '0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    settle();
    cf("after reset", 7'h40);
    chk("out b default", {12'h000, term_seen}, 16'h0004);
    for (int i = 0; i < 9; i++) rd(4'(i), dflt[i]);
    rd(4'h9, 14'h0000);
    drive(stf_pkg::MODE_SPEED, 1'b0, 16'sh02ee, 16'sh07d0, 16'sh012b, 0, 16'sh02ee);
    cf("cmd at thr2", 7'h70);
    drive(stf_pkg::MODE_SPEED, 1'b0, 16'sh02ed, 0, 16'sh05dc, 0, 16'sh02ed);
    cf("est at thr3", 7'h67);
    drive(stf_pkg::MODE_SPEED, 1'b0, 16'sh012b, 0, 16'sh012c, 0, 16'sh012b);
    cf("thr1 edge", 7'h44);
    drive(stf_pkg::MODE_SPEED, 1'b0, -16'sh012c, 0, -16'sh05db, 0, -16'sh012c);
    cf("reverse same", 7'h66);
    drive(stf_pkg::MODE_SPEED, 1'b1, 16'sh03e8, 16'sh044c, 0, 0, 16'sh03e8);
    cf("band edge", 7'h76);
    drive(stf_pkg::MODE_SPEED, 1'b1, 16'sh03e8, 16'sh044d, 0, 0, 16'sh03e8);
    cf("band out", 7'h36);
    drive(stf_pkg::MODE_TORQUE, 1'b1, 16'sh07d0, 16'sh07d0, 0, 0, 16'sh07d0);
    cf("torque", 7'h47);
    drive(stf_pkg::MODE_POSITION, 1'b1, 16'sh07d0, 16'sh07d0, 0, 0, 16'sh07d0);
    cf("position", 7'h47);
    drive(stf_pkg::MODE_VF, 1'b1, 0, 0, 0, 16'sh0320, 16'sh0320);
    cf("vf", 7'h76);
    for (int k = 0; k < 3; k++) begin
      drive(stf_pkg::MODE_SPEED, 1'b0, 16'sh07d0, 0, 16'sh07d0, 0, 16'sh07d0);
      cf("all on", 7'h7f);
      @(posedge clk);
      alarm             <= (k == 0);
      output_stop_input <= (k == 1);
      drive_reset_input <= (k == 2);
      settle();
      cf("cleared", 7'h40);
      @(posedge clk);
      {alarm, output_stop_input, drive_reset_input} <= 3'h0;
    end
    wr(4'h2, 14'h01f4, 1'b0);
    drive(stf_pkg::MODE_SPEED, 1'b0, -16'sh0190, 0, -16'sh01f4, 0, -16'sh0190);
    cf("reverse thr", 7'h44);
    drive(stf_pkg::MODE_SPEED, 1'b0, 16'sh0190, 0, 16'sh0190, 0, 16'sh0190);
    cf("forward thr", 7'h64);
    wr(4'h0, 14'h0000, 1'b0);
    drive(stf_pkg::MODE_SPEED, 1'b0, 16'sh03e9, 0, 0, 0, 16'sh03e8);
    cf("zero band", 7'h30);
    wr(4'h0, 14'h000a, 1'b0);
    wr(4'h3, 14'h0000, 1'b0);
    drive(stf_pkg::MODE_SPEED, 1'b0, 0, 0, 0, 0, 0);
    cf("zero no start", 7'h40);
    @(posedge clk);
    start_cmd <= 1'b1;
    settle();
    cf("zero start", 7'h52);
    wr(4'h3, 14'h02ee, 1'b0);
    wr(4'h0, 14'h0065, 1'b1);
    wr(4'h1, 14'h0e11, 1'b1);
    wr(4'h2, 14'h270e, 1'b1);
    wr(4'h5, 14'h0002, 1'b1);
    wr(4'h9, 14'h0001, 1'b1);
    wr(4'h0, 14'h0064, 1'b0);
    rd(4'h0, 14'h0064);
    for (int k = 0; k < 8; k++) begin
      e1 = (k >= 1 && k <= 3);
      e2 = (k == 0 || (k >= 4 && k <= 6));
      for (int i = 0; i < 4; i++) wr(4'(5 + i), codes[k], 1'b0);
      drive(stf_pkg::MODE_SPEED, 1'b0, 16'sh0640, 0, 0, 0, 0);
      chk("routed cmd", {12'h000, term_seen}, {12'h000, {4{e1}}});
      drive(stf_pkg::MODE_SPEED, 1'b0, 0, 0, 16'sh0640, 0, 0);
      chk("routed fbk", {12'h000, term_seen}, {12'h000, {4{e2}}});
    end
    wr(4'h5, 14'h0004, 1'b0);
    wr(4'h6, 14'h0001, 1'b0);
    wr(4'h7, 14'h0007, 1'b0);
    drive(stf_pkg::MODE_SPEED, 1'b0, 16'sh0640, 0, 0, 0, 0);
    chk("mixed s1", {12'h000, term_seen}, 16'h0008);
    drive(stf_pkg::MODE_SPEED, 1'b0, 0, 0, 16'sh0640, 0, 0);
    chk("mixed s2", {12'h000, term_seen}, 16'h0006);
    finish_test();
  end
endmodule : tb_speed_threshold_flags

`default_nettype wire
